// [core/mpcc_pkg.sv]
// mpcc_pkg: constants for the memory protection and cache control unit
// assumes: used by mpcc_top and mpcc_region_match, referenced as mpcc_pkg::name
package mpcc_pkg;
    localparam int NUM_AREAS = 8;
    // coprocessor register numbers
    localparam logic [3:0] REG_CONTROL = 4'h1;
    localparam logic [3:0] REG_CACHEABLE = 4'h2;
    localparam logic [3:0] REG_PERMISSION = 4'h5;
    localparam logic [3:0] REG_REGION = 4'h6;
    localparam logic [3:0] REG_FLUSH = 4'h7;
    // control register fields
    localparam int CTRL_CACHE_EN_BIT = 2;
    localparam int CTRL_PROTECTION_ON = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h0000_0005;
    localparam logic [31:0] CACHEABLE_MASK = 32'h0000_00FF;
    localparam logic [31:0] PERMISSION_MASK = 32'h0000_FFFF;
    // region definition fields
    localparam int REGION_BASE_LSB = 12;
    localparam int REGION_BASE_W = 20;
    localparam int REGION_SIZE_LSB = 1;
    localparam int REGION_SIZE_W = 5;
    localparam int REGION_EN_BIT = 0;
    localparam logic [31:0] REGION_MASK = 32'hFFFF_F03F;
    localparam logic [4:0] SIZE_MIN_CODE = 5'h0B;
    // permission encodings
    localparam logic [1:0] AP_NONE = 2'h0;
    localparam logic [1:0] AP_SUPER = 2'h1;
    localparam logic [1:0] AP_USER_RO = 2'h2;
    localparam logic [1:0] AP_FULL = 2'h3;
    typedef enum logic [1:0] {MPCC_IDLE, MPCC_FLUSH} mpcc_flush_state_t;
endpackage : mpcc_pkg

// [core/mpcc_region_if.sv]
// mpcc_region_if: carries one region's definition and the match answer
// assumes: one instance per area, driven by mpcc_top
`timescale 1ns/1ns
interface mpcc_region_if;
    logic [31:0] definition;
    logic [31:0] addr;
    logic hit;
    modport ctrl (output definition, output addr, input hit);
    modport match (input definition, input addr, output hit);
endinterface : mpcc_region_if

// [core/mpcc_region_match.sv]
// mpcc_region_match: decides whether an address falls in one region
// assumes: definition word laid out as base/size/enable
`timescale 1ns/1ns
module mpcc_region_match (
    mpcc_region_if.match rgn
);
    logic [4:0] size_code;
    logic [31:0] mask;
    always_comb begin
        size_code = rgn.definition[mpcc_pkg::REGION_SIZE_LSB +: mpcc_pkg::REGION_SIZE_W];
        // size N covers 2^(N+1) bytes; code 31 covers all memory
        mask = (size_code == 5'h1F) ? 32'h0000_0000 : (32'hFFFF_FFFF << (size_code + 5'h01));
        rgn.hit = rgn.definition[mpcc_pkg::REGION_EN_BIT]
                  && (size_code >= mpcc_pkg::SIZE_MIN_CODE)
                  && (((rgn.addr ^ rgn.definition) & mask) == 32'h0000_0000);
    end
endmodule : mpcc_region_match

// [core/mpcc_top.sv]
// mpcc_top: coprocessor-mapped protection and cache control registers
// assumes: core issues register transfers and memory accesses on the clock
// What this block does
// - control: cache enable bit 2, protection enable bit 0, reset zero
// - cacheable register: bit n marks area n cacheable, upper bits reserved
// - permission register: two bits per area at 2n+1:2n, upper bits reserved
// - permission codes: none, supervisor only, user read only, full
// - any write to flush register invalidates whole cache; nothing readable
// - eight region definitions, chosen by secondary selector on register 6
// - region base address in bits 31:12; bits 11:6 reserved
// - region size code in bits 5:1; codes 01011 to 11111 valid
// - region enable bit 0, cleared by reset; base and size undefined
// - overlapping regions: higher area number wins
// - protection on: access outside all enabled regions aborts
// - protection off: every access is non-cacheable
// - register transfers accepted only in privileged mode
`timescale 1ns/1ns
module mpcc_top #(
    parameter int NUM_AREAS = mpcc_pkg::NUM_AREAS
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic cp_valid,
    input wire logic cp_write,
    input wire logic cp_privileged,
    input wire logic [3:0] cp_reg_num,
    input wire logic [3:0] secondary_register_selector,
    input wire logic [31:0] cp_wdata,
    output logic [31:0] cp_rdata,
    output logic cp_accepted,
    input wire logic mem_valid,
    input wire logic [31:0] mem_addr,
    input wire logic mem_write,
    input wire logic mem_privileged,
    output logic mem_abort,
    output logic mem_cacheable,
    output logic cache_enable,
    output logic protection_on,
    output logic cache_invalidate
);
    logic [31:0] protection_cache_control_q;
    logic [31:0] protection_cache_control_d;
    logic [31:0] area_cacheable_flags_q;
    logic [31:0] area_cacheable_flags_d;
    logic [31:0] area_access_permissions_q;
    logic [31:0] area_access_permissions_d;
    // base and size sit apart from the enable so that only the enable needs a reset
    logic [30:0] region_cfg_q [NUM_AREAS];
    logic [30:0] region_cfg_d [NUM_AREAS];
    logic [NUM_AREAS-1:0] region_en_q;
    logic [NUM_AREAS-1:0] region_en_d;
    logic [31:0] region_word [NUM_AREAS];
    mpcc_pkg::mpcc_flush_state_t flush_state_q;
    mpcc_pkg::mpcc_flush_state_t flush_state_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic accepted_q;
    logic accepted_d;
    logic xfer_ok;
    logic [NUM_AREAS-1:0] hit;
    mpcc_region_if rgn [NUM_AREAS] ();

    for (genvar g = 0; g < NUM_AREAS; g++) begin : g_area
        // reserved bits are masked here so they read zero even before the first write
        assign region_word[g] = {region_cfg_q[g], region_en_q[g]} & mpcc_pkg::REGION_MASK;
        assign rgn[g].definition = region_word[g];
        assign rgn[g].addr = mem_addr;
        assign hit[g] = rgn[g].hit;
        mpcc_region_match u_match (
            .rgn(rgn[g])
        );
    end

    // unprivileged transfers are simply ignored; a read leaves the previous read word on cp_rdata
    assign xfer_ok = cp_valid && cp_privileged;

    always_comb begin
        protection_cache_control_d = protection_cache_control_q;
        area_cacheable_flags_d = area_cacheable_flags_q;
        area_access_permissions_d = area_access_permissions_q;
        region_cfg_d = region_cfg_q;
        region_en_d = region_en_q;
        flush_state_d = mpcc_pkg::MPCC_IDLE;
        if (xfer_ok && cp_write) begin
            case (cp_reg_num)
                mpcc_pkg::REG_CONTROL: begin
                    protection_cache_control_d = cp_wdata & mpcc_pkg::CTRL_MASK;
                end
                mpcc_pkg::REG_CACHEABLE: begin
                    area_cacheable_flags_d = cp_wdata & mpcc_pkg::CACHEABLE_MASK;
                end
                mpcc_pkg::REG_PERMISSION: begin
                    area_access_permissions_d = cp_wdata & mpcc_pkg::PERMISSION_MASK;
                end
                mpcc_pkg::REG_REGION: begin
                    if (secondary_register_selector < 4'(NUM_AREAS)) begin
                        region_cfg_d[secondary_register_selector[2:0]] = cp_wdata[31:1];
                        region_en_d[secondary_register_selector[2:0]] = cp_wdata[mpcc_pkg::REGION_EN_BIT];
                    end
                end
                mpcc_pkg::REG_FLUSH: begin
                    flush_state_d = mpcc_pkg::MPCC_FLUSH;
                end
                default: begin
                end
            endcase
        end
    end

    // read decode: the word is registered and held until the next privileged read
    always_comb begin
        rdata_d = rdata_q;
        accepted_d = xfer_ok;
        if (xfer_ok && !cp_write) begin
            case (cp_reg_num)
                mpcc_pkg::REG_CONTROL: rdata_d = protection_cache_control_q;
                mpcc_pkg::REG_CACHEABLE: rdata_d = area_cacheable_flags_q;
                mpcc_pkg::REG_PERMISSION: rdata_d = area_access_permissions_q;
                mpcc_pkg::REG_REGION: begin
                    rdata_d = (secondary_register_selector < 4'(NUM_AREAS)) ?
                        region_word[secondary_register_selector[2:0]] : 32'h0000_0000;
                end
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // control, region enables and bus outputs start from known values
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            protection_cache_control_q <= mpcc_pkg::CTRL_RESET;
            flush_state_q <= mpcc_pkg::MPCC_IDLE;
            rdata_q <= 32'h0000_0000;
            accepted_q <= 1'b0;
            region_en_q <= '0;
        end else begin
            protection_cache_control_q <= protection_cache_control_d;
            flush_state_q <= flush_state_d;
            rdata_q <= rdata_d;
            accepted_q <= accepted_d;
            region_en_q <= region_en_d;
        end
    end

    // no reset here: these come up unknown and must be loaded before protection is enabled
    always_ff @(posedge clock) begin
        area_cacheable_flags_q <= area_cacheable_flags_d;
        area_access_permissions_q <= area_access_permissions_d;
        region_cfg_q <= region_cfg_d;
    end

    // access decision: highest-numbered hitting area sets the attributes
    logic sel_found;
    logic [2:0] sel_area;
    logic [1:0] sel_ap;
    logic perm_ok;
    always_comb begin
        sel_found = 1'b0;
        sel_area = 3'h0;
        for (int i = 0; i < NUM_AREAS; i++) begin
            if (hit[i]) begin
                sel_found = 1'b1;
                sel_area = 3'(i);
            end
        end
        sel_ap = area_access_permissions_q[2*sel_area +: 2];
        case (sel_ap)
            mpcc_pkg::AP_NONE: perm_ok = 1'b0;
            mpcc_pkg::AP_SUPER: perm_ok = mem_privileged;
            mpcc_pkg::AP_USER_RO: perm_ok = mem_privileged || !mem_write;
            mpcc_pkg::AP_FULL: perm_ok = 1'b1;
            default: perm_ok = 1'b0;
        endcase
    end

    assign protection_on = protection_cache_control_q[mpcc_pkg::CTRL_PROTECTION_ON];
    assign cache_enable = protection_cache_control_q[mpcc_pkg::CTRL_CACHE_EN_BIT];
    assign cache_invalidate = (flush_state_q == mpcc_pkg::MPCC_FLUSH);
    assign cp_rdata = rdata_q;
    assign cp_accepted = accepted_q;
    // combinational so the core can abort in the same cycle as the access
    assign mem_abort = mem_valid && protection_on && (!sel_found || !perm_ok);
    assign mem_cacheable = mem_valid && protection_on && sel_found
                           && area_cacheable_flags_q[sel_area];
endmodule : mpcc_top

// [bench/mpcc_checker.sv]
// mpcc_checker: port-level assertions for mpcc_top
// assumes: bound to mpcc_top, sees only its ports
`timescale 1ns/1ns
module mpcc_checker (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic cp_valid,
    input wire logic cp_write,
    input wire logic cp_privileged,
    input wire logic [3:0] cp_reg_num,
    input wire logic [3:0] secondary_register_selector,
    input wire logic [31:0] cp_wdata,
    input wire logic [31:0] cp_rdata,
    input wire logic [31:0] mem_addr,
    input wire logic cp_accepted,
    input wire logic mem_valid,
    input wire logic mem_write,
    input wire logic mem_privileged,
    input wire logic mem_abort,
    input wire logic mem_cacheable,
    input wire logic cache_enable,
    input wire logic protection_on,
    input wire logic cache_invalidate
);
    logic tk, wr, rd;
    assign tk = cp_valid && cp_privileged;
    assign wr = tk && cp_write;
    assign rd = tk && !cp_write;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_ctrl_reset: assert property ($fell(sys_rst) |-> !cache_enable && !protection_on)
        else $error("control not clear after reset");
    a_take_priv: assert property (tk |=> cp_accepted)
        else $error("privileged transfer not accepted");
    a_refuse_user: assert property (!tk |=> !cp_accepted)
        else $error("accept without privileged transfer");
    a_ctrl_bits: assert property (wr && cp_reg_num == mpcc_pkg::REG_CONTROL |=>
        cache_enable == $past(cp_wdata[2]) && protection_on == $past(cp_wdata[0]))
        else $error("control bits wrong");
    a_flush_pulse: assert property (wr && cp_reg_num == mpcc_pkg::REG_FLUSH |=> cache_invalidate)
        else $error("flush write gave no pulse");
    a_flush_cause: assert property (cache_invalidate |-> $past(wr && cp_reg_num == 4'h7))
        else $error("flush pulse without write");
    a_empty_read: assert property (rd && cp_reg_num inside {4'h0, 4'h3, 4'h4, 4'h7} |=> cp_rdata == 32'h0)
        else $error("empty register read nonzero");
    a_ctrl_rsvd: assert property (rd && cp_reg_num == 4'h1 |=> (cp_rdata & 32'hFFFF_FFFA) == 32'h0)
        else $error("control reserved bits set");
    a_area_rsvd: assert property (rd && cp_reg_num == 4'h6 |=> cp_rdata[11:6] == 6'h00)
        else $error("region reserved bits set");
    a_prot_off: assert property (!protection_on |-> !mem_abort && !mem_cacheable)
        else $error("access attributes while protection off");
endmodule : mpcc_checker
bind mpcc_top mpcc_checker mpcc_checker_i (.*);

// [bench/mpcc_core.sv]
// mpcc_core: processor model issuing transfers and memory accesses
// assumes: one clock; requests launched at a rising edge
`timescale 1ns/1ns
module mpcc_core (
    input wire logic clock,
    input wire logic cp_accepted,
    input wire logic [31:0] cp_rdata,
    output logic cp_valid,
    output logic cp_write,
    output logic cp_privileged,
    output logic mem_valid,
    output logic mem_write,
    output logic mem_privileged,
    output logic [3:0] cp_reg_num,
    output logic [3:0] secondary_register_selector,
    output logic [31:0] cp_wdata,
    output logic [31:0] mem_addr
);
    initial begin
        {cp_valid, cp_write, cp_privileged, mem_valid, mem_write, mem_privileged} = 6'h00;
        {cp_reg_num, secondary_register_selector, cp_wdata, mem_addr} = 72'h0;
    end
    task automatic xfer(input logic p, w, input logic [3:0] r, s, input logic [31:0] d,
                        output logic a, output logic [31:0] q);
        @(posedge clock);
        cp_valid <= 1'b1;
        cp_privileged <= p;
        cp_write <= w;
        cp_reg_num <= r;
        secondary_register_selector <= s;
        cp_wdata <= d;
        @(posedge clock);
        cp_valid <= 1'b0;
        cp_wdata <= ~d; // released data must not look valid
        #1;
        a = cp_accepted;
        q = cp_rdata;
    endtask : xfer
    task automatic acc(input logic [31:0] ad, input logic w, p);
        @(posedge clock);
        mem_valid <= 1'b1;
        mem_addr <= ad;
        mem_write <= w;
        mem_privileged <= p;
        #1;
    endtask : acc
endmodule : mpcc_core

// [bench/mpcc_top_test.sv]
// mpcc_top_test: self-checking bench for mpcc_top
// assumes: mpcc_core drives all transfer and access inputs
`timescale 1ns/1ns
module mpcc_top_test;
    logic clock, sys_rst, cp_valid, cp_write, cp_privileged, cp_accepted, mem_valid, mem_write;
    logic mem_privileged, mem_abort, mem_cacheable, cache_enable, protection_on, cache_invalidate;
    logic [3:0] cp_reg_num, secondary_register_selector;
    logic [31:0] cp_wdata, cp_rdata, mem_addr, q;
    logic a;
    int num_errors = 0;
    int cmp_count = 0;
    mpcc_top mpcc_top_i (.*);
    mpcc_core mpcc_core_i (.*);
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic chk(input string n, input logic [31:0] e, s);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [3:0] r, s, input logic [31:0] d);
        mpcc_core_i.xfer(1'b1, 1'b1, r, s, d, a, q);
    endtask : wr
    task automatic rchk(input logic [3:0] r, s, input logic [31:0] m, e);
        mpcc_core_i.xfer(1'b1, 1'b0, r, s, 32'h0, a, q);
        chk("read data", e, q & m);
        chk("accepted", 32'h1, {31'h0, a});
    endtask : rchk
    task automatic mchk(input logic [31:0] ad, input logic w, p, ab, ca);
        mpcc_core_i.acc(ad, w, p);
        chk("abort", {31'h0, ab}, {31'h0, mem_abort});
        chk("cacheable", {31'h0, ca}, {31'h0, mem_cacheable});
    endtask : mchk
    task automatic t_reset;
        chk("cache_enable", 32'h0, {31'h0, cache_enable});
        chk("protection_on", 32'h0, {31'h0, protection_on});
        rchk(4'h1, 4'h0, 32'hFFFF_FFFF, 32'h0);
        for (int i = 0; i < 8; i++) rchk(4'h6, 4'(i), 32'h1, 32'h0);
    endtask : t_reset
    task automatic t_rerun;
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        t_reset;
    endtask : t_rerun
    task automatic t_unpriv;
        mpcc_core_i.xfer(1'b0, 1'b1, 4'h1, 4'h0, 32'h5, a, q);
        chk("accepted", 32'h0, {31'h0, a});
        mpcc_core_i.xfer(1'b0, 1'b0, 4'h1, 4'h0, 32'h0, a, q);
        chk("accepted", 32'h0, {31'h0, a});
        rchk(4'h1, 4'h0, 32'hFFFF_FFFF, 32'h0);
    endtask : t_unpriv
    task automatic t_regs;
        logic [3:0] r [8] = '{4'h1, 4'h2, 4'h5, 4'h6, 4'h7, 4'h3, 4'h0, 4'h4};
        logic [31:0] e [8] = '{32'h5, 32'hFF, 32'hFFFF, 32'hFFFF_F03F, 32'h0, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 8; i++) begin
            wr(r[i], 4'h2, 32'hFFFF_FFFF);
            chk("flush", {31'h0, r[i] == 4'h7}, {31'h0, cache_invalidate});
            rchk(r[i], 4'h2, 32'hFFFF_FFFF, e[i]);
        end
    endtask : t_regs
    task automatic t_select;
        for (int i = 0; i < 8; i++) wr(4'h6, 4'(i), {12'h0, 8'(i), 12'h016});
        wr(4'h6, 4'h8, 32'hFFFF_FFFF);
        rchk(4'h6, 4'h8, 32'hFFFF_FFFF, 32'h0);
        for (int i = 0; i < 8; i++) rchk(4'h6, 4'(i), 32'hFFFF_FFFF, {12'h0, 8'(i), 12'h016});
    endtask : t_select
    task automatic t_access;
        wr(4'h6, 4'h0, 32'h0000_003F);
        wr(4'h6, 4'h7, 32'h1000_0017);
        wr(4'h6, 4'h1, 32'h2000_0015);
        wr(4'h2, 4'h0, 32'h1);
        wr(4'h1, 4'h0, 32'h5);
        for (int k = 0; k < 4; k++) begin
            wr(4'h5, 4'h0, {16'h0, 2'(k), 10'h0, 4'hF});
            mchk(32'h1000_0FFC, 1'b0, 1'b0, k < 2, 1'b0);
            mchk(32'h1000_0FFC, 1'b1, 1'b0, k != 3, 1'b0);
            mchk(32'h1000_0000, 1'b1, 1'b1, k == 0, 1'b0);
        end
        mchk(32'h1000_1000, 1'b1, 1'b0, 1'b0, 1'b1);
        wr(4'h6, 4'h0, 32'h0000_003E);
        mchk(32'h2000_0000, 1'b0, 1'b1, 1'b1, 1'b0);
        wr(4'h6, 4'h0, 32'h0000_003F);
        mchk(32'h2000_0000, 1'b1, 1'b0, 1'b0, 1'b1);
        wr(4'h1, 4'h0, 32'h4);
        chk("cache_enable", 32'h1, {31'h0, cache_enable});
        chk("protection_on", 32'h0, {31'h0, protection_on});
        mchk(32'h2000_0000, 1'b1, 1'b0, 1'b0, 1'b0);
    endtask : t_access
    task automatic results;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results
    initial begin
        #2000000;
        num_errors++;
        results;
    end
    initial begin
        sys_rst = 1'b1;
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        t_reset;
        t_unpriv;
        t_regs;
        t_select;
        t_access;
        t_rerun;
        results;
    end
endmodule : mpcc_top_test
